// file: rtl/server_map.vh
`ifndef SERVER_MAP_VH
`define SERVER_MAP_VH
// Register byte addresses
`define REG_STATUS_WORD   8'h00
`define REG_SELECT_MASK   8'h04
`define REG_ENGINE_STATUS 8'h08
`define REG_CB_BASE       8'h40
`define REG_CB_LAST       8'hbc
// Status word fields
`define SW_SERVER_EN      0
`define SW_GLOBAL_EN      1
`define SW_STACK_EXT      2
`define SW_FLAGS_LO       4
`define SW_FLAGS_HI       7
`define SW_RESET          8'h00
`define SEL_RESET         8'h00
// Control block word indices (16-bit words)
`define CB_CTL            2'd0
`define CB_SRC            2'd1
`define CB_DST            2'd2
`define CB_CNT            2'd3
`define CB_CNT_BYTE_OFS   6
// Control word fields
`define CTL_MODE_HI       7
`define CTL_MODE_LO       5
`define CTL_DST_INC       0
`define CTL_SRC_INC       1
`define CTL_SRC_KEEP      3
// Mode codes
`define MODE_BLOCK        3'b000
`define MODE_OUT_EVENT    3'b001
`define MODE_IN_CAPTURE   3'b011
`define MODE_SINGLE       3'b100
`define MODE_SCAN         3'b110
// Instruction codes on the CPU instruction port
`define OP_OTHER          2'b00
`define OP_SERVER_ENABLE  2'b01
`define OP_SERVER_DISABLE 2'b10
// Timing
`define CLK_PERIOD_NS     5
`define STATE_TIME_NS     5
`define RESP_INT_ST       11
`define RESP_EXT_ST       13
`define SAMPLE_ST         4
`define LONGEST_INSTR_ST  39
`define MAX_LATENCY_ST    56
`define RESP_INT_CYC      ((`RESP_INT_ST * `STATE_TIME_NS) / `CLK_PERIOD_NS)
`define RESP_EXT_CYC      ((`RESP_EXT_ST * `STATE_TIME_NS) / `CLK_PERIOD_NS)
`endif

// file: rtl/control_block_ram.v
`timescale 1ns/1ps
// Control blocks of all sources, registered read
module control_block_ram (
  // Clock
  input  wire        hclk,
  // Port
  input  wire        we,
  input  wire [4:0]  addr,
  input  wire [15:0] wdata,
  output reg  [15:0] rdata
);
  reg [15:0] mem [0:31];

  always @(posedge hclk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule // control_block_ram

// file: rtl/source_pointer_calc.v
`timescale 1ns/1ps
`include "server_map.vh"
// Source pointer after one transfer and at the end of a service cycle
module source_pointer_calc (
  // Inputs
  input  wire [7:0]  ctl,
  input  wire [15:0] src,
  input  wire [15:0] src_orig,
  // Results
  output reg  [15:0] src_step,
  output reg  [15:0] src_end
);
  wire [2:0]  mode = ctl[`CTL_MODE_HI:`CTL_MODE_LO];
  wire [15:0] inc  = src + 16'h0001;

  always @* begin
    src_step = src;
    src_end  = src;
    case (mode)
      `MODE_SINGLE: begin
        if (ctl[`CTL_SRC_INC] && ctl[`CTL_SRC_KEEP]) begin
          src_end = inc;
        end
      end
      `MODE_BLOCK: begin
        if (ctl[`CTL_SRC_INC]) begin
          src_step = inc;
        end
        if (!ctl[`CTL_SRC_KEEP]) begin
          src_end = src_orig;
        end
      end
      `MODE_OUT_EVENT: begin
        if (ctl[`CTL_SRC_KEEP]) begin
          src_end = inc;
        end
      end
      `MODE_IN_CAPTURE, `MODE_SCAN: begin
        src_end = src;
      end
      default: begin
        src_end = src;
      end
    endcase
  end
endmodule // source_pointer_calc

// file: rtl/interrupt_transfer_server.v
`timescale 1ns/1ps
`include "server_map.vh"
module interrupt_transfer_server (
  // Clock and reset
  input  wire        hclk,
  input  wire        hresetn,
  // AHB-Lite slave
  input  wire        hsel,
  input  wire [7:0]  haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire        hready,
  input  wire [31:0] hwdata,
  output wire [31:0] hrdata,
  output wire        hreadyout,
  output wire        hresp,
  // Interrupt sources
  input  wire [7:0]  irq_req,
  // CPU instruction stream
  input  wire        instr_done,
  input  wire [1:0]  instr_op,
  // Standard vector call to the CPU
  output reg         vector_call_q,
  output reg  [2:0]  vector_id_q,
  // Data memory port, read data one cycle after read strobe
  output reg         dmem_re_q,
  output reg         dmem_we_q,
  output reg  [15:0] dmem_addr_q,
  output reg  [15:0] dmem_wdata_q,
  input  wire [15:0] dmem_rdata
);
  localparam [3:0] S_IDLE = 4'd0;
  localparam [3:0] S_CTL  = 4'd1;
  localparam [3:0] S_SRC  = 4'd2;
  localparam [3:0] S_DST  = 4'd3;
  localparam [3:0] S_CNT  = 4'd4;
  localparam [3:0] S_LD   = 4'd5;
  localparam [3:0] S_RD   = 4'd6;
  localparam [3:0] S_RW   = 4'd7;
  localparam [3:0] S_WR   = 4'd8;
  localparam [3:0] S_NX   = 4'd9;
  localparam [3:0] S_WB   = 4'd10;
  localparam [3:0] S_WC   = 4'd11;
  localparam [3:0] S_WN   = 4'd12;
  localparam [3:0] S_STD  = 4'd13;

  // Lowest numbered pending source wins
  function [2:0] first_set;
    input [7:0] v;
    integer i;
    begin
      first_set = 3'd0;
      for (i = 7; i >= 0; i = i - 1) begin
        if (v[i]) begin
          first_set = i[2:0];
        end
      end
    end
  endfunction

  reg  [7:0]  status_q;
  reg  [7:0]  select_q;
  reg  [7:0]  pend_q;
  reg         inhibit_q;
  reg  [3:0]  state_q;
  reg  [2:0]  id_q;
  reg  [7:0]  ctl_q;
  reg  [15:0] src_q;
  reg  [15:0] org_q;
  reg  [15:0] dst_q;
  reg  [15:0] cnt_q;
  reg  [4:0]  resp_q;
  reg         dp_act_q;
  reg         dp_wr_q;
  reg         dp_mem_q;
  reg         dp_done_q;
  reg  [7:0]  dp_addr_q;
  reg  [31:0] rd_q;
  reg  [7:0]  clr;
  reg  [1:0]  cb_word;
  reg         cb_we;
  reg  [15:0] cb_wdata;

  wire [15:0] cb_rdata;
  wire [15:0] src_step;
  wire [15:0] src_end;
  wire        busy    = (state_q != S_IDLE);
  wire [2:0]  mode    = ctl_q[`CTL_MODE_HI:`CTL_MODE_LO];
  wire        is_blk  = (mode == `MODE_BLOCK);
  wire        addr_ok = hsel && hready && htrans[1];
  wire        a_mem   = (haddr >= `REG_CB_BASE) && (haddr <= `REG_CB_LAST);
  wire        bus_go  = dp_act_q && dp_mem_q && !dp_done_q && !busy;
  wire [7:0]  pend_d  = (pend_q & ~clr) | irq_req;
  wire [2:0]  pick    = first_set(pend_q);
  // Acknowledge gated by global enable and the post-instruction window
  wire        ack_ok  = status_q[`SW_GLOBAL_EN] && !inhibit_q;
  wire        start   = !busy && (pend_q != 8'h00) && ack_ok &&
                        !(dp_act_q && dp_mem_q && !dp_done_q);
  wire        to_srv  = status_q[`SW_SERVER_EN] && select_q[pick];
  wire [31:0] resp_int = `RESP_INT_CYC;
  wire [31:0] resp_ext = `RESP_EXT_CYC;
  wire [4:0]  resp_n  = status_q[`SW_STACK_EXT] ? resp_ext[4:0] : resp_int[4:0];
  // Bus words are numbered from the first control block, as the engine numbers them
  wire [7:0]  cb_ofs  = dp_addr_q - `REG_CB_BASE;
  wire [4:0]  cb_addr = busy ? {id_q, cb_word} : cb_ofs[6:2];

  assign hresp     = 1'b0;
  assign hreadyout = !(dp_act_q && dp_mem_q && !dp_done_q);
  assign hrdata    = dp_mem_q ? {16'h0000, cb_rdata} : rd_q;

  control_block_ram u_cb (
    .hclk  (hclk),
    .we    (cb_we),
    .addr  (cb_addr),
    .wdata (cb_wdata),
    .rdata (cb_rdata)
  );

  source_pointer_calc u_ptr (
    .ctl      (ctl_q),
    .src      (src_q),
    .src_orig (org_q),
    .src_step (src_step),
    .src_end  (src_end)
  );

  // Control block port: engine owns it for a whole service cycle
  always @* begin
    cb_word  = `CB_CTL;
    cb_we    = 1'b0;
    cb_wdata = hwdata[15:0];
    case (state_q)
      S_IDLE: begin
        cb_we = bus_go && dp_wr_q;
      end
      // Read is registered: the word addressed here is captured in the next state
      S_SRC: begin
        cb_word = `CB_SRC;
      end
      S_DST: begin
        cb_word = `CB_DST;
      end
      S_CNT: begin
        cb_word = `CB_CNT;
      end
      S_WB: begin
        cb_word  = `CB_SRC;
        cb_we    = 1'b1;
        cb_wdata = src_q;
      end
      S_WC: begin
        cb_word  = `CB_DST;
        cb_we    = 1'b1;
        cb_wdata = dst_q;
      end
      S_WN: begin
        cb_word  = `CB_CNT;
        cb_we    = 1'b1;
        cb_wdata = cnt_q;
      end
      default: begin
        cb_word = `CB_CTL;
      end
    endcase
  end

  always @* begin
    clr = 8'h00;
    if (start) begin
      clr[pick] = 1'b1;
    end
  end

  // Bus data phase and register file
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_act_q  <= 1'b0;
      dp_wr_q   <= 1'b0;
      dp_mem_q  <= 1'b0;
      dp_done_q <= 1'b0;
      dp_addr_q <= 8'h00;
      rd_q      <= 32'h00000000;
      status_q  <= `SW_RESET;
      select_q  <= `SEL_RESET;
      inhibit_q <= 1'b0;
    end else begin
      if (bus_go) begin
        dp_done_q <= 1'b1;
      end
      if (hreadyout) begin
        dp_act_q  <= addr_ok;
        dp_wr_q   <= hwrite;
        dp_mem_q  <= addr_ok && a_mem;
        dp_done_q <= 1'b0;
        dp_addr_q <= haddr;
        case (haddr)
          `REG_STATUS_WORD:   rd_q <= {24'h000000, status_q};
          `REG_SELECT_MASK:   rd_q <= {24'h000000, select_q};
          `REG_ENGINE_STATUS: rd_q <= {16'h0000, pend_q, 3'b000, inhibit_q,
                                       state_q};
          default:            rd_q <= 32'h00000000;
        endcase
      end
      if (dp_act_q && dp_wr_q && !dp_mem_q) begin
        case (dp_addr_q)
          `REG_STATUS_WORD: status_q <= hwdata[7:0];
          `REG_SELECT_MASK: select_q <= hwdata[7:0];
          default:          select_q <= select_q;
        endcase
      end
      if (instr_done) begin
        case (instr_op)
          `OP_SERVER_ENABLE: begin
            status_q[`SW_SERVER_EN] <= 1'b1;
            inhibit_q               <= 1'b1;
          end
          `OP_SERVER_DISABLE: begin
            status_q[`SW_SERVER_EN] <= 1'b0;
            inhibit_q               <= 1'b1;
          end
          default: begin
            inhibit_q <= 1'b0;
          end
        endcase
      end
    end
  end

  // Service engine
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q       <= S_IDLE;
      pend_q        <= 8'h00;
      id_q          <= 3'd0;
      ctl_q         <= 8'h00;
      src_q         <= 16'h0000;
      org_q         <= 16'h0000;
      dst_q         <= 16'h0000;
      cnt_q         <= 16'h0000;
      resp_q        <= 5'd0;
      vector_call_q <= 1'b0;
      vector_id_q   <= 3'd0;
      dmem_re_q     <= 1'b0;
      dmem_we_q     <= 1'b0;
      dmem_addr_q   <= 16'h0000;
      dmem_wdata_q  <= 16'h0000;
    end else begin
      pend_q        <= pend_d;
      vector_call_q <= 1'b0;
      dmem_re_q     <= 1'b0;
      dmem_we_q     <= 1'b0;
      case (state_q)
        S_IDLE: begin
          if (start) begin
            id_q   <= pick;
            resp_q <= resp_n;
            state_q <= to_srv ? S_CTL : S_STD;
          end
        end
        S_STD: begin
          if (resp_q <= 5'd1) begin
            vector_call_q <= 1'b1;
            vector_id_q   <= id_q;
            state_q       <= S_IDLE;
          end else begin
            resp_q <= resp_q - 5'd1;
          end
        end
        S_CTL: begin
          state_q <= S_SRC;
        end
        S_SRC: begin
          ctl_q   <= cb_rdata[7:0];
          state_q <= S_DST;
        end
        S_DST: begin
          src_q   <= cb_rdata;
          org_q   <= cb_rdata;
          state_q <= S_CNT;
        end
        S_CNT: begin
          dst_q   <= cb_rdata;
          state_q <= S_LD;
        end
        S_LD: begin
          cnt_q <= cb_rdata;
          if (is_blk && (cb_rdata == 16'h0000)) begin
            state_q <= S_WB;
          end else begin
            state_q <= S_RD;
          end
        end
        S_RD: begin
          dmem_re_q   <= 1'b1;
          dmem_addr_q <= src_q;
          state_q     <= S_RW;
        end
        S_RW: begin
          state_q <= S_WR;
        end
        S_WR: begin
          dmem_we_q    <= 1'b1;
          dmem_addr_q  <= dst_q;
          dmem_wdata_q <= dmem_rdata;
          if (is_blk) begin
            src_q <= src_step;
            cnt_q <= cnt_q - 16'h0001;
            if (ctl_q[`CTL_DST_INC]) begin
              dst_q <= dst_q + 16'h0001;
            end
          end
          state_q <= S_NX;
        end
        S_NX: begin
          if (is_blk && (cnt_q != 16'h0000)) begin
            state_q <= S_RD;
          end else begin
            src_q   <= src_end;
            state_q <= S_WB;
          end
        end
        S_WB: begin
          state_q <= S_WC;
        end
        S_WC: begin
          state_q <= S_WN;
        end
        S_WN: begin
          state_q <= S_IDLE;
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end
endmodule // interrupt_transfer_server

// file: bench/data_memory_model.sv
`timescale 1ns/1ps
module data_memory_model (
  // Clock
  input  wire         hclk,
  // Memory port
  input  wire         dmem_re_q,
  input  wire         dmem_we_q,
  input  wire  [15:0] dmem_addr_q,
  input  wire  [15:0] dmem_wdata_q,
  output logic [15:0] dmem_rdata
);
  logic [15:0] mem [0:65535];
  initial begin
    for (int a = 0; a < 65536; a++) begin
      mem[a] = 16'(a) ^ 16'hc3a5;
    end
    dmem_rdata = 16'h0000;
  end
  // Read data is valid one cycle only, then the port shows a changing pattern
  always @(posedge hclk) begin
    if (dmem_we_q) begin
      mem[dmem_addr_q] <= dmem_wdata_q;
    end
    if (dmem_re_q) begin
      dmem_rdata <= mem[dmem_addr_q];
    end else begin
      dmem_rdata <= ~dmem_rdata;
    end
  end
endmodule // data_memory_model

// file: bench/interrupt_transfer_server_asserts.sv
`timescale 1ns/1ps
`include "server_map.vh"
module server_checker (
  // Clock and reset
  input wire        hclk,
  input wire        hresetn,
  // Register bus
  input wire        hsel,
  input wire [7:0]  haddr,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire [2:0]  hsize,
  input wire        hready,
  input wire [31:0] hwdata,
  input wire [31:0] hrdata,
  input wire        hreadyout,
  input wire        hresp,
  // Interrupts and CPU
  input wire [7:0]  irq_req,
  input wire        instr_done,
  input wire [1:0]  instr_op,
  input wire        vector_call_q,
  input wire [2:0]  vector_id_q,
  // Data memory
  input wire        dmem_re_q,
  input wire        dmem_we_q,
  input wire [15:0] dmem_addr_q,
  input wire [15:0] dmem_wdata_q,
  input wire [15:0] dmem_rdata
);
  logic inh_q;
  wire  take  = hsel && hready && htrans[1];
  wire  in_cb = (haddr >= `REG_CB_BASE) && (haddr <= `REG_CB_LAST);
  default clocking dc @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Acknowledge inhibit as the CPU stream implies it
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      inh_q <= 1'b0;
    end else if (instr_done) begin
      inh_q <= (instr_op != `OP_OTHER);
    end
  end
  sequence s_cb_take;
    take && in_cb;
  endsequence
  sequence s_move;
    dmem_re_q ##[1:2] dmem_we_q;
  endsequence
  AST_REG_NOWAIT: assert property (take && haddr < 8'h40 |=> hreadyout)
    else $error("register access stalled");
  AST_CB_WAIT: assert property (s_cb_take |=> !hreadyout)
    else $error("block access without wait");
  AST_CB_BOUND: assert property (s_cb_take |-> ##[2:1000] hreadyout)
    else $error("block access never answered");
  AST_VEC_PULSE: assert property (vector_call_q |=> !vector_call_q)
    else $error("vector call longer than one cycle");
  AST_MOVE: assert property (dmem_re_q |-> s_move)
    else $error("read without write");
  AST_EXCL: assert property (!(dmem_re_q && dmem_we_q))
    else $error("read and write together");
  AST_INHIBIT: assert property (vector_call_q |->
    !($past(inh_q, 12) && $past(inh_q, 14)))
    else $error("interrupt taken while inhibited");
  AST_VEC_QUIET: assert property (vector_call_q |-> !dmem_re_q && !dmem_we_q)
    else $error("transfer during vector call");
endmodule // server_checker
bind interrupt_transfer_server server_checker u_chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .irq_req(irq_req), .instr_done(instr_done),
  .instr_op(instr_op), .vector_call_q(vector_call_q), .vector_id_q(vector_id_q),
  .dmem_re_q(dmem_re_q), .dmem_we_q(dmem_we_q), .dmem_addr_q(dmem_addr_q),
  .dmem_wdata_q(dmem_wdata_q), .dmem_rdata(dmem_rdata));

// file: bench/tb_interrupt_transfer_server.sv
`timescale 1ns/1ps
`include "server_map.vh"
module tb_interrupt_transfer_server;
  logic        hclk, hresetn, hsel, hwrite, hrdy, hresp, instr_done, vc, re, we, blk;
  logic [1:0]  htrans, op;
  logic [2:0]  vid, md;
  logic [7:0]  haddr, irq, f, ctl, base;
  logic [15:0] da, dw, dr, src, dst, cnt, la, sa, k;
  logic [31:0] hwdata, hrdata, rd;
  int          err_count, tests_run, cyc, n, j, lat[2];
  logic [2:0]  md_t[5] = '{`MODE_BLOCK, `MODE_OUT_EVENT, `MODE_IN_CAPTURE, `MODE_SINGLE,
                           `MODE_SCAN};
  interrupt_transfer_server uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hready(hrdy),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hrdy), .hresp(hresp), .irq_req(irq),
    .instr_done(instr_done), .instr_op(op), .vector_call_q(vc), .vector_id_q(vid),
    .dmem_re_q(re), .dmem_we_q(we), .dmem_addr_q(da), .dmem_wdata_q(dw), .dmem_rdata(dr));
  data_memory_model mem_m (.hclk(hclk), .dmem_re_q(re), .dmem_we_q(we),
    .dmem_addr_q(da), .dmem_wdata_q(dw), .dmem_rdata(dr));
  function automatic logic [15:0] ini(input logic [15:0] a);
    return a ^ 16'hc3a5;
  endfunction
  function automatic logic [15:0] src_end(input logic [7:0] c, input logic [15:0] s, m);
    case (c[7:5])
      `MODE_BLOCK:     return c[3] ? s + (c[1] ? m : 16'h0) : s;
      `MODE_SINGLE:    return s + 16'(c[1] & c[3]);
      `MODE_OUT_EVENT: return s + 16'(c[3]);
      default:         return s;
    endcase
  endfunction
  task automatic chk(input logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= a;
    do @(posedge hclk); while (!hrdy);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (!hrdy);
    rd = hrdata;
  endtask
  task automatic cpu(input logic [1:0] o);
    instr_done <= 1'b1;
    op <= o;
    @(posedge hclk);
    instr_done <= 1'b0;
    @(posedge hclk);
  endtask
  task automatic wait_vec();
    n = 0;
    while (!vc && n < 200) begin
      @(posedge hclk);
      n++;
    end
  endtask
  task automatic fire(input int s);
    irq <= 8'h01 << s;
    @(posedge hclk);
    irq <= 8'h00;
    wait_vec();
  endtask
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 40000) begin
      err_count++;
      summarize();
    end
  end
  initial begin
    {hresetn, hsel, hwrite, instr_done, htrans, op, haddr, irq, hwdata} = '0;
    void'($urandom(42));
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(0, `REG_STATUS_WORD, 0);
    chk(rd, `SW_RESET);
    chk(hresp, 0);
    bus(0, `REG_SELECT_MASK, 0);
    chk(rd, `SEL_RESET);
    f = 8'($urandom) & 8'hf0;
    bus(1, `REG_STATUS_WORD, {24'h0, f | 8'h02});
    bus(1, 8'hc0, $urandom);
    bus(0, 8'hc0, 0);
    chk(rd, 0);
    cpu(`OP_SERVER_ENABLE);
    bus(0, `REG_ENGINE_STATUS, 0);
    chk(rd[4], 1);
    bus(0, `REG_STATUS_WORD, 0);
    chk(rd, {24'h0, f | 8'h03});
    cpu(`OP_OTHER);
    bus(0, `REG_ENGINE_STATUS, 0);
    chk(rd[4], 0);
    cpu(`OP_SERVER_DISABLE);
    cpu(`OP_OTHER);
    bus(0, `REG_STATUS_WORD, 0);
    chk(rd, {24'h0, f | 8'h02});
    for (int e = 0; e < 2; e++) begin
      bus(1, `REG_STATUS_WORD, {29'h0, e[0], 2'b10});
      j = $urandom % 8;
      fire(j);
      chk(vid, j);
      lat[e] = n;
    end
    chk(lat[1] - lat[0], 2);
    chk(lat[1] <= 56, 1);
    cpu(`OP_SERVER_ENABLE);
    fire(3);
    chk(n, 200);
    cpu(`OP_OTHER);
    wait_vec();
    chk(vid, 3);
    for (int it = 0; it < 10; it++) begin
      md = md_t[it % 5];
      blk = (md == `MODE_BLOCK);
      j = $urandom % 8;
      ctl = {md, 5'h0} | (8'($urandom) & 8'h0b);
      src = 16'h1000 + 16'($urandom % 256);
      dst = 16'h8000 + 16'(it * 16);
      cnt = (it == 0) ? 16'h0 : 16'(1 + $urandom % 4);
      base = `REG_CB_BASE + 8'(j * 16);
      bus(1, base, {24'h0, ctl});
      bus(1, base + 8'h04, {16'h0, src});
      bus(1, base + 8'h08, {16'h0, dst});
      bus(1, base + 8'h0c, {16'h0, cnt});
      bus(1, `REG_SELECT_MASK, 32'h1 << j);
      irq <= 8'h01 << j;
      @(posedge hclk);
      irq <= 8'h00;
      @(posedge hclk);
      n = 0;
      do begin
        bus(0, `REG_ENGINE_STATUS, 0);
        n++;
      end while ((rd & 32'hff0f) != 0 && n < 300);
      bus(0, base + 8'h04, 0);
      chk(rd, {16'h0, src_end(ctl, src, cnt)});
      if (blk) begin
        bus(0, base + 8'h0c, 0);
        chk(rd, 0);
      end
      k = (blk && cnt != 0) ? cnt - 16'h1 : 16'h0;
      la = dst + ((blk && ctl[0]) ? k : 16'h0);
      sa = src + ((blk && ctl[1]) ? k : 16'h0);
      chk(mem_m.mem[la], (blk && cnt == 0) ? ini(dst) : ini(sa));
    end
    cpu(`OP_SERVER_DISABLE);
    cpu(`OP_OTHER);
    fire(j);
    chk(vid, j);
    summarize();
  end
endmodule // tb_interrupt_transfer_server
